// >>> hw/adc_conv_ctrl.sv
// converter control: clock divider, start selection, tracking, flags, input select, bus slave
// Behaviour
// - conversion clock is system clock divided by divider setting plus one, 0..31
// - conversion rates up to 200 ksps are supported
// - exactly one start source, chosen by the start-source field, starts conversions
// - busy bit stays one throughout the conversion, clears at completion
// - busy falling at completion sets the done flag and an enabled interrupt request
// - result registers hold the new result when the done flag reads one
// - timers 2 and 3 use low-byte overflow in 8-bit mode, else high-byte
// - normal track mode tracks continuously except during conversion
// - low-power track mode tracks 3 conversion clocks after start, then converts
// - low-power with strobe source: track while strobe low, convert on rising edge
// - tracking is shut down during chip standby or sleep
// - results have 10 bits resolution
// - input codes 0..0x14 are port inputs, 0x1E temperature, 0x1F supply
// - upper three bits of the positive select read zero, writes ignored
// - largest package: codes 0..3 are reserved
// - smallest package: codes 0x11..0x14 are reserved
// - start-source encoding: sw, timer0, timer2, timer1, strobe, timer3; 11x reserved
// - writing one to busy starts only when source field is 000
// - with power-on bit zero the converter stays shut down
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module adc_conv_ctrl #(
	parameter logic [1:0] PACKAGE_VARIANT = adc_ctrl_pkg::PKG_MID
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// start sources
	input  wire logic        tmr0_ovf,
	input  wire logic        tmr1_ovf,
	input  wire logic        tmr2_lo_ovf,
	input  wire logic        tmr2_hi_ovf,
	input  wire logic        tmr2_split,
	input  wire logic        tmr3_lo_ovf,
	input  wire logic        tmr3_hi_ovf,
	input  wire logic        tmr3_split,
	input  wire logic        external_convert_strobe,
	// power state, analog front end and interrupt
	input  wire logic        standby,
	input  wire logic        cmp_in,
	output logic             track_en,
	output logic             analog_power,
	output logic      [9:0]  dac_code,
	output logic      [4:0]  positive_input_code,
	output logic             input_code_valid,
	output logic             conv_irq
);
	typedef enum logic [1:0] {S_IDLE, S_TRACK, S_CONV} seq_e;

	sar_if sar ();
	sar_engine u_engine (.clk(clk), .srst(srst), .sar(sar.engine));

	// ****************************
	// bus slave
	// ****************************
	logic [7:0]  control_q, config_q, pos_mux_q, aux_q;
	logic [9:0]  result_q;
	logic        wr_q, rd_q;
	logic [9:0]  idx_q;
	logic [31:0] hrdata_q;
	logic        hreadyout_q;
	logic [7:0]  rd_byte;
	logic        wr_ctrl;
	logic        sw_one;

	always_ff @(posedge clk) begin
		if (srst) begin
			wr_q  <= 1'b0;
			rd_q  <= 1'b0;
			idx_q <= 10'h000;
		end else begin
			wr_q <= hsel && htrans[1] && hready && hwrite;
			rd_q <= hsel && htrans[1] && hready && !hwrite;
			if (hsel && htrans[1] && hready) begin
				idx_q <= haddr[11:2];
			end
		end
	end

	// reads take one wait state so a write just before is already visible
	always_comb begin
		rd_byte = 8'h00;
		unique case (idx_q)
			adc_ctrl_pkg::IDX_CONTROL: rd_byte = control_q;
			adc_ctrl_pkg::IDX_CONFIG:  rd_byte = {config_q[7:2], 2'b00};
			adc_ctrl_pkg::IDX_POS_MUX: rd_byte = {3'b000, pos_mux_q[4:0]};
			adc_ctrl_pkg::IDX_AUX:     rd_byte = aux_q;
			adc_ctrl_pkg::IDX_RES_HI:  rd_byte = config_q[adc_ctrl_pkg::CFG_LJUST] ?
				result_q[9:2] : {6'b000000, result_q[9:8]};
			adc_ctrl_pkg::IDX_RES_LO:  rd_byte = config_q[adc_ctrl_pkg::CFG_LJUST] ?
				{result_q[1:0], 6'b000000} : result_q[7:0];
			default:                   rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			hrdata_q    <= 32'h0000_0000;
			hreadyout_q <= 1'b1;
		end else begin
			hreadyout_q <= !(hsel && htrans[1] && hready && !hwrite);
			if (rd_q) begin
				hrdata_q <= {24'h000000, rd_byte};
			end
		end
	end

	assign wr_ctrl = wr_q && idx_q == adc_ctrl_pkg::IDX_CONTROL;
	// the start decision uses the source field being written alongside
	assign sw_one  = wr_ctrl && hwdata[adc_ctrl_pkg::CTL_BUSY] &&
		hwdata[adc_ctrl_pkg::CTL_SRC_HI:0] == adc_ctrl_pkg::SRC_SW;

	always_ff @(posedge clk) begin
		if (srst) begin
			config_q  <= adc_ctrl_pkg::RST_CONFIG;
			pos_mux_q <= adc_ctrl_pkg::RST_POS_MUX;
			aux_q     <= adc_ctrl_pkg::RST_AUX;
		end else if (wr_q) begin
			if (idx_q == adc_ctrl_pkg::IDX_CONFIG) config_q <= {hwdata[7:2], 2'b00};
			if (idx_q == adc_ctrl_pkg::IDX_POS_MUX) pos_mux_q <= {3'b000, hwdata[4:0]};
			if (idx_q == adc_ctrl_pkg::IDX_AUX) aux_q <= {7'h00, hwdata[adc_ctrl_pkg::AUX_IRQ_EN]};
		end
	end

	// ****************************
	// conversion clock divider
	// ****************************
	logic [4:0] div_cnt_q;
	logic       tick_q;
	logic [4:0] divider;
	logic       start_q;
	assign divider = config_q[adc_ctrl_pkg::CFG_DIV_HI:adc_ctrl_pkg::CFG_DIV_LO];

	// divide by setting plus one; slowest settings keep the rate well under the limit
	always_ff @(posedge clk) begin
		if (srst || !control_q[adc_ctrl_pkg::CTL_POWER]) begin
			div_cnt_q <= 5'h00;
			tick_q    <= 1'b0;
		end else if (start_q) begin
			// restart on engine start: the first trial gets a full period for the comparator path
			div_cnt_q <= 5'h00;
			tick_q    <= 1'b0;
		end else begin
			tick_q    <= div_cnt_q >= divider;
			div_cnt_q <= (div_cnt_q >= divider) ? 5'h00 : div_cnt_q + 5'h01;
		end
	end

	// ****************************
	// start sources
	// ****************************
	logic strb_s1_q, strb_s2_q, strb_prev_q;
	logic strb_rise;
	logic trig;
	logic [2:0] src;
	assign src = control_q[adc_ctrl_pkg::CTL_SRC_HI:0];

	always_ff @(posedge clk) begin
		if (srst) begin
			strb_s1_q   <= 1'b0;
			strb_s2_q   <= 1'b0;
			strb_prev_q <= 1'b0;
		end else begin
			strb_s1_q   <= external_convert_strobe;
			strb_s2_q   <= strb_s1_q;
			strb_prev_q <= strb_s2_q;
		end
	end
	assign strb_rise = strb_s2_q && !strb_prev_q;

	always_comb begin
		unique case (src)
			adc_ctrl_pkg::SRC_SW:     trig = sw_one;
			adc_ctrl_pkg::SRC_TMR0:   trig = tmr0_ovf;
			adc_ctrl_pkg::SRC_TMR2:   trig = tmr2_split ? tmr2_lo_ovf : tmr2_hi_ovf;
			adc_ctrl_pkg::SRC_TMR1:   trig = tmr1_ovf;
			adc_ctrl_pkg::SRC_STROBE: trig = strb_rise;
			adc_ctrl_pkg::SRC_TMR3:   trig = tmr3_split ? tmr3_lo_ovf : tmr3_hi_ovf;
			default:                  trig = 1'b0;
		endcase
	end

	// ****************************
	// sequencer
	// ****************************
	seq_e       state_q;
	logic [1:0] trk_cnt_q;
	logic       power;
	logic       lp_mode;
	logic       fin;
	assign power   = control_q[adc_ctrl_pkg::CTL_POWER];
	assign lp_mode = control_q[adc_ctrl_pkg::CTL_TRACK];
	assign fin     = state_q == S_CONV && sar.done;

	always_ff @(posedge clk) begin
		if (srst || !power) begin
			state_q   <= S_IDLE;
			trk_cnt_q <= 2'h0;
			start_q   <= 1'b0;
		end else begin
			start_q <= 1'b0;
			unique case (state_q)
				S_IDLE: if (trig) begin
					trk_cnt_q <= 2'h0;
					if (lp_mode && src != adc_ctrl_pkg::SRC_STROBE) begin
						state_q <= S_TRACK;
					end else begin
						state_q <= S_CONV;
						start_q <= 1'b1;
					end
				end
				S_TRACK: if (tick_q) begin
					trk_cnt_q <= trk_cnt_q + 2'h1;
					if (trk_cnt_q == 2'(adc_ctrl_pkg::TRACK_TICKS - 1)) begin
						state_q <= S_CONV;
						start_q <= 1'b1;
					end
				end
				// further starts are not looked at until the engine finishes
				S_CONV: if (sar.done) state_q <= S_IDLE;
			endcase
		end
	end

	assign sar.start = start_q;
	assign sar.tick  = tick_q;

	// ****************************
	// control register, flags and result
	// ****************************
	logic cmp_s1_q, cmp_s2_q;
	logic irq_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			cmp_s1_q <= 1'b0;
			cmp_s2_q <= 1'b0;
		end else begin
			cmp_s1_q <= cmp_in;
			cmp_s2_q <= cmp_s1_q;
		end
	end
	assign sar.cmp = cmp_s2_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			control_q <= adc_ctrl_pkg::RST_CONTROL;
		end else begin
			if (wr_ctrl) begin
				control_q[7:6] <= hwdata[7:6];
				control_q[adc_ctrl_pkg::CTL_SRC_HI:0] <= hwdata[adc_ctrl_pkg::CTL_SRC_HI:0];
			end
			// set beats a software clear landing in the same cycle
			if (fin) begin
				control_q[adc_ctrl_pkg::CTL_DONE] <= 1'b1;
			end else if (wr_ctrl) begin
				control_q[adc_ctrl_pkg::CTL_DONE] <= hwdata[adc_ctrl_pkg::CTL_DONE];
			end
			control_q[adc_ctrl_pkg::CTL_BUSY] <= (state_q != S_IDLE && !fin) ||
				(state_q == S_IDLE && trig && power);
			control_q[3] <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			result_q <= 10'h000;
			irq_q    <= 1'b0;
		end else begin
			if (fin) result_q <= sar.result;
			irq_q <= fin && aux_q[adc_ctrl_pkg::AUX_IRQ_EN];
		end
	end

	// ****************************
	// tracking and input select
	// ****************************
	logic       track_q, apow_q, valid_q;
	logic [4:0] code_q;
	logic [9:0] dac_q;
	logic [4:0] code;
	assign code = pos_mux_q[4:0];

	always_ff @(posedge clk) begin
		if (srst) begin
			track_q <= 1'b0;
			apow_q  <= 1'b0;
			dac_q   <= 10'h000;
		end else begin
			apow_q <= power && !standby;
			dac_q  <= sar.trial;
			if (!power || standby) begin
				track_q <= 1'b0;
			end else if (!lp_mode) begin
				track_q <= state_q != S_CONV;
			end else if (src == adc_ctrl_pkg::SRC_STROBE) begin
				track_q <= state_q == S_IDLE && !strb_s2_q;
			end else begin
				track_q <= state_q == S_TRACK;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			code_q  <= 5'h00;
			valid_q <= 1'b0;
		end else begin
			code_q  <= code;
			valid_q <= code == adc_ctrl_pkg::MUX_TEMP || code == adc_ctrl_pkg::MUX_SUPPLY ||
				(code <= adc_ctrl_pkg::MUX_PORT_LAST &&
				!(PACKAGE_VARIANT == adc_ctrl_pkg::PKG_LARGE && code <= adc_ctrl_pkg::MUX_LARGE_LAST) &&
				!(PACKAGE_VARIANT == adc_ctrl_pkg::PKG_SMALL && code >= adc_ctrl_pkg::MUX_SMALL_FIRST));
		end
	end

	assign hrdata              = hrdata_q;
	assign hreadyout           = hreadyout_q;
	assign hresp               = 1'b0;
	assign track_en            = track_q;
	assign analog_power        = apow_q;
	assign dac_code            = dac_q;
	assign positive_input_code = code_q;
	assign input_code_valid    = valid_q;
	assign conv_irq            = irq_q;

	// ****************************
	// checks
	// ****************************
	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_track_end;
		state_q == S_TRACK && tick_q && trk_cnt_q == 2'h2;
	endsequence
	sequence s_conv_begun;
		state_q == S_CONV && start_q;
	endsequence

	chk_busy_held: assert property (state_q == S_CONV && !sar.done |=> control_q[4])
		else $error("busy dropped during conversion");
	chk_done_on_fall: assert property ($fell(control_q[4]) |-> control_q[5])
		else $error("done flag not set when busy fell");
	chk_result_ready: assert property ($rose(control_q[5]) && power |-> result_q == $past(sar.result))
		else $error("result not loaded with done flag");
	chk_track_three: assert property (s_track_end |=> s_conv_begun)
		else $error("low-power tracking not three clocks");
	chk_no_retrigger: assert property (state_q == S_CONV && !sar.done |=> state_q == S_CONV)
		else $error("running conversion disturbed");
	chk_power_off: assert property (!power |=> state_q == S_IDLE && !track_q)
		else $error("converter active while powered off");
	chk_normal_track: assert property (state_q == S_CONV |=> !track_q)
		else $error("tracking during conversion");
	chk_sw_gate: assert property (state_q == S_IDLE && power && sw_one && src != adc_ctrl_pkg::SRC_SW
		&& !trig |=> state_q == S_IDLE)
		else $error("software write started with wrong source");
	chk_div_tick: assert property (tick_q && $past(power) |-> $past(div_cnt_q) >= $past(divider))
		else $error("conversion clock tick off divider");
	chk_reserved_code: assert property (code > adc_ctrl_pkg::MUX_PORT_LAST && code < adc_ctrl_pkg::MUX_TEMP
		|=> !valid_q)
		else $error("reserved input code accepted");
endmodule // adc_conv_ctrl
`default_nettype wire

// >>> hw/sar_engine.sv
// successive-approximation bit-trial engine, one bit per conversion clock
`timescale 1ns/1ps
`default_nettype none
module sar_engine (
	// clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// sequencer side
	sar_if.engine     sar
);
	logic [9:0] trial_q;
	logic [9:0] bit_q;
	logic [3:0] ticks_q;
	logic       run_q;
	logic       done_q;
	logic [9:0] result_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			run_q   <= 1'b0;
			trial_q <= 10'h000;
			bit_q   <= 10'h000;
			ticks_q <= 4'h0;
		end else if (sar.start) begin
			run_q   <= 1'b1;
			trial_q <= 10'h200;
			bit_q   <= 10'h200;
			ticks_q <= 4'h0;
		end else if (run_q && sar.tick) begin
			// keep the bit while the comparator says input is above the trial
			trial_q <= (sar.cmp ? trial_q : (trial_q & ~bit_q)) | (bit_q >> 1);
			bit_q   <= bit_q >> 1;
			ticks_q <= ticks_q + 4'h1;
			if (bit_q[0]) begin
				run_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			done_q   <= 1'b0;
			result_q <= 10'h000;
		end else begin
			done_q <= run_q && sar.tick && bit_q[0];
			if (run_q && sar.tick && bit_q[0]) begin
				result_q <= sar.cmp ? trial_q : (trial_q & ~bit_q);
			end
		end
	end

	assign sar.done   = done_q;
	assign sar.trial  = trial_q;
	assign sar.result = result_q;

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	chk_bit_count: assert property (done_q |-> ticks_q == 4'(adc_ctrl_pkg::RES_BITS))
		else $error("conversion did not take one clock per bit");
endmodule // sar_engine
`default_nettype wire

// >>> inc/adc_ctrl_pkg.sv
// constants shared by the converter control block and its sequencing engine
package adc_ctrl_pkg;
	// ****************************
	// register word indices (byte address = 4 * index)
	// ****************************
	localparam logic [9:0] IDX_POS_MUX = 10'h0BB;
	localparam logic [9:0] IDX_CONFIG  = 10'h0BC;
	localparam logic [9:0] IDX_RES_LO  = 10'h0BD;
	localparam logic [9:0] IDX_RES_HI  = 10'h0BE;
	localparam logic [9:0] IDX_AUX     = 10'h0C0;
	localparam logic [9:0] IDX_CONTROL = 10'h0E8;
	// ****************************
	// reset values
	// ****************************
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_CONFIG  = 8'hF8;
	localparam logic [7:0] RST_POS_MUX = 8'h00;
	localparam logic [7:0] RST_AUX     = 8'h00;
	// ****************************
	// field positions
	// ****************************
	localparam int CTL_POWER = 7;
	localparam int CTL_TRACK = 6;
	localparam int CTL_DONE  = 5;
	localparam int CTL_BUSY  = 4;
	localparam int CTL_SRC_HI = 2;
	localparam int CFG_DIV_HI = 7;
	localparam int CFG_DIV_LO = 3;
	localparam int CFG_LJUST  = 2;
	localparam int AUX_IRQ_EN = 0;
	// ****************************
	// start sources and input codes
	// ****************************
	localparam logic [2:0] SRC_SW     = 3'h0;
	localparam logic [2:0] SRC_TMR0   = 3'h1;
	localparam logic [2:0] SRC_TMR2   = 3'h2;
	localparam logic [2:0] SRC_TMR1   = 3'h3;
	localparam logic [2:0] SRC_STROBE = 3'h4;
	localparam logic [2:0] SRC_TMR3   = 3'h5;
	localparam logic [4:0] MUX_PORT_LAST  = 5'h14;
	localparam logic [4:0] MUX_LARGE_LAST = 5'h03;
	localparam logic [4:0] MUX_SMALL_FIRST = 5'h11;
	localparam logic [4:0] MUX_TEMP   = 5'h1E;
	localparam logic [4:0] MUX_SUPPLY = 5'h1F;
	localparam logic [1:0] PKG_MID   = 2'h0;
	localparam logic [1:0] PKG_LARGE = 2'h1;
	localparam logic [1:0] PKG_SMALL = 2'h2;
	// ****************************
	// timing
	// ****************************
	localparam int RES_BITS    = 10;
	localparam int TRACK_TICKS = 3;
	localparam int CLK_HZ      = 40000000;
	localparam int MAX_KSPS    = 200;
	localparam int MIN_CONV_CYCLES = CLK_HZ / (MAX_KSPS * 1000);
endpackage

// >>> inc/sar_if.sv
// handshake between the conversion sequencer and the bit-trial engine
`timescale 1ns/1ps
`default_nettype none
interface sar_if;
	logic       start;
	logic       tick;
	logic       cmp;
	logic       done;
	logic [9:0] trial;
	logic [9:0] result;
	modport ctrl (output start, output tick, output cmp, input done, input trial, input result);
	modport engine (input start, input tick, input cmp, output done, output trial, output result);
endinterface
`default_nettype wire

// >>> testbench/adc_partner.sv
// stand-in for the on-chip timers and the analog input seen by the comparator
`timescale 1ns/1ps
`default_nettype none
module adc_partner (
	// clock
	input  wire logic       clk,
	// commands from the bench, trial code from the converter
	input  wire logic       go,
	input  wire logic [2:0] which,
	input  wire logic       wrong,
	input  wire logic       s2,
	input  wire logic       s3,
	input  wire logic [9:0] vin,
	input  wire logic [9:0] dac_code,
	// towards the converter
	output logic            tmr0_ovf,
	output logic            tmr1_ovf,
	output logic            tmr2_lo_ovf,
	output logic            tmr2_hi_ovf,
	output logic            tmr2_split,
	output logic            tmr3_lo_ovf,
	output logic            tmr3_hi_ovf,
	output logic            tmr3_split,
	output logic            cmp_in
);
	// ****************************
	// timer overflows
	// ****************************
	// wrong asks for the overflow of the byte the mode does not use
	always_ff @(posedge clk) begin
		tmr0_ovf    <= go && which == adc_ctrl_pkg::SRC_TMR0;
		tmr1_ovf    <= go && which == adc_ctrl_pkg::SRC_TMR1;
		tmr2_lo_ovf <= go && which == adc_ctrl_pkg::SRC_TMR2 && (s2 ^ wrong);
		tmr2_hi_ovf <= go && which == adc_ctrl_pkg::SRC_TMR2 && !(s2 ^ wrong);
		tmr3_lo_ovf <= go && which == adc_ctrl_pkg::SRC_TMR3 && (s3 ^ wrong);
		tmr3_hi_ovf <= go && which == adc_ctrl_pkg::SRC_TMR3 && !(s3 ^ wrong);
	end
	assign tmr2_split = s2;
	assign tmr3_split = s3;
	// ****************************
	// comparator
	// ****************************
	// input sits half an lsb above vin, so a trial never ties
	assign cmp_in = vin >= dac_code;
endmodule // adc_partner
`default_nettype wire

// >>> testbench/tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb;
	// ****************************
	// signals
	// ****************************
	logic        clk = 0, srst = 1, hsel = 0, hwrite = 0, hreadyout, hresp;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [1:0]  htrans = 0;
	logic [2:0]  which = 0;
	logic        standby = 0, strobe = 0, go = 0, wrong = 0, s2 = 0, s3 = 0, cmp_in, track_en, analog_power;
	logic        t0o, t1o, t2l, t2h, t2s, t3l, t3h, t3s, code_ok, conv_irq;
	logic [9:0]  vin = 0, dac_code;
	logic [4:0]  pcode, c;
	int          n_errors = 0, total_checks = 0, cyc = 0, n_irq = 0, t_irq = 0, d, t0, n0, k;
	int          exp_q[$];
	logic [9:0]  ridx [7] = '{adc_ctrl_pkg::IDX_CONTROL, adc_ctrl_pkg::IDX_CONFIG, adc_ctrl_pkg::IDX_POS_MUX,
		adc_ctrl_pkg::IDX_RES_HI, adc_ctrl_pkg::IDX_RES_LO, adc_ctrl_pkg::IDX_AUX, 10'h3FF};
	logic [7:0]  rexp [7] = '{adc_ctrl_pkg::RST_CONTROL, adc_ctrl_pkg::RST_CONFIG, adc_ctrl_pkg::RST_POS_MUX,
		8'h00, 8'h00, adc_ctrl_pkg::RST_AUX, 8'h00};
	logic [4:0]  codes [6] = '{5'h00, 5'h14, 5'h15, 5'h1D, 5'h1E, 5'h1F};

	initial begin
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (conv_irq === 1'b1) begin
			n_irq <= n_irq + 1;
			t_irq <= cyc;
		end
	end

	adc_conv_ctrl uut (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.tmr0_ovf(t0o), .tmr1_ovf(t1o), .tmr2_lo_ovf(t2l), .tmr2_hi_ovf(t2h), .tmr2_split(t2s),
		.tmr3_lo_ovf(t3l), .tmr3_hi_ovf(t3h), .tmr3_split(t3s), .external_convert_strobe(strobe),
		.standby(standby), .cmp_in(cmp_in), .track_en(track_en), .analog_power(analog_power),
		.dac_code(dac_code), .positive_input_code(pcode), .input_code_valid(code_ok), .conv_irq(conv_irq));
	adc_partner tmr (.clk(clk), .go(go), .which(which), .wrong(wrong), .s2(s2), .s3(s3), .vin(vin),
		.dac_code(dac_code), .tmr0_ovf(t0o), .tmr1_ovf(t1o), .tmr2_lo_ovf(t2l), .tmr2_hi_ovf(t2h),
		.tmr2_split(t2s), .tmr3_lo_ovf(t3l), .tmr3_hi_ovf(t3h), .tmr3_split(t3s), .cmp_in(cmp_in));

	// ****************************
	// tasks
	// ****************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// one single word transfer; read data lands in rd
	task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] wv);
		@(posedge clk);
		hsel   <= 1;
		haddr  <= {20'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel   <= 0;
		hwdata <= {24'h0, wv};
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic fire(input logic [2:0] w, input logic bad);
		@(posedge clk);
		go    <= 1;
		which <= w;
		wrong <= bad;
		@(posedge clk);
		go <= 0;
	endtask
	task automatic trigger(input logic [2:0] src, input logic tm);
		if (src == adc_ctrl_pkg::SRC_SW) bus(1, adc_ctrl_pkg::IDX_CONTROL, {1'b1, tm, 3'h2, src});
		else if (src == adc_ctrl_pkg::SRC_STROBE) begin
			@(posedge clk);
			strobe <= 0;
			repeat (4) @(posedge clk);
			strobe <= 1;
		end
		else fire(src, 0);
	endtask
	task automatic convert(input logic [2:0] src, input logic tm);
		int nt;
		int v;
		nt = (tm && src != adc_ctrl_pkg::SRC_STROBE) ? 13 : 10;
		v = $urandom_range(0, 1023);
		exp_q.push_back(v);
		vin    <= 10'(v);
		s2     <= 1'($urandom);
		s3     <= 1'($urandom);
		strobe <= 0;
		bus(1, adc_ctrl_pkg::IDX_CONTROL, {1'b1, tm, 3'h0, src});
		// a foreign source and a wrong-byte overflow must not start anything
		fire(src == 3'h5 ? 3'h1 : src + 3'h1, 0);
		if (src == adc_ctrl_pkg::SRC_TMR2 || src == adc_ctrl_pkg::SRC_TMR3) fire(src, 1);
		repeat (6) @(posedge clk);
		n0 = n_irq;
		trigger(src, tm);
		t0 = cyc;
		repeat (8) @(posedge clk);
		if (!tm) chk(track_en, 0, "tracking while converting");
		bus(0, adc_ctrl_pkg::IDX_CONTROL, 0);
		chk(rd[4], 1, "busy during conversion");
		trigger(src, tm);
		k = 0;
		do begin
			bus(0, adc_ctrl_pkg::IDX_CONTROL, 0);
			k++;
		end while (rd[5] !== 1'b1 && k < 100);
		chk(rd[5:4], 2'h2, "done set, busy clear");
		chk(n_irq - n0, 1, "one request per conversion");
		k = t_irq - t0;
		chk(k > (nt - 1) * (d + 1) && k <= nt * (d + 1) + d + 8, 1, "conversion length");
		v = exp_q.pop_front();
		bus(0, adc_ctrl_pkg::IDX_RES_HI, 0);
		chk(rd, 32'(v >> 8), "result high");
		bus(0, adc_ctrl_pkg::IDX_RES_LO, 0);
		chk(rd, 32'(v & 255), "result low");
	endtask

	// ****************************
	// sequence
	// ****************************
	initial begin
		void'($urandom(32'h95A002DC));
		repeat (6) @(posedge clk);
		srst <= 0;
		foreach (ridx[i]) begin
			bus(0, ridx[i], 0);
			chk(rd, {24'h0, rexp[i]}, "reset value");
		end
		bus(1, adc_ctrl_pkg::IDX_POS_MUX, 8'hFF);
		bus(0, adc_ctrl_pkg::IDX_POS_MUX, 0);
		chk(rd, 32'h1F, "upper select bits");
		for (int i = 0; i < 12; i++) begin
			c = i < 6 ? codes[i] : 5'($urandom);
			bus(1, adc_ctrl_pkg::IDX_POS_MUX, {3'h7, c});
			bus(0, adc_ctrl_pkg::IDX_POS_MUX, 0);
			chk({rd[7:0], pcode, code_ok}, {3'h0, c, c, c <= 5'h14 || c >= 5'h1E}, "input select");
		end
		d = $urandom_range(3, 6);
		bus(1, adc_ctrl_pkg::IDX_CONFIG, {5'(d), 3'h0});
		bus(0, adc_ctrl_pkg::IDX_CONFIG, 0);
		chk(rd, {24'h0, 5'(d), 3'h0}, "divider setting");
		bus(1, adc_ctrl_pkg::IDX_AUX, 8'h01);
		bus(1, adc_ctrl_pkg::IDX_CONTROL, 8'h10);
		repeat (60) @(posedge clk);
		bus(0, adc_ctrl_pkg::IDX_CONTROL, 0);
		chk({rd, analog_power}, 0, "start while powered down");
		bus(1, adc_ctrl_pkg::IDX_CONTROL, 8'h81);
		bus(1, adc_ctrl_pkg::IDX_CONTROL, 8'h91);
		repeat (60) @(posedge clk);
		bus(0, adc_ctrl_pkg::IDX_CONTROL, 0);
		chk({rd, 8'(n_irq)}, 40'h8100, "busy write with timer source");
		for (int s = 0; s < 6; s++) begin
			for (int t = 0; t < 2; t++) begin
				convert(3'(s), 1'(t));
			end
		end
		bus(1, adc_ctrl_pkg::IDX_CONTROL, 8'h80);
		repeat (4) @(posedge clk);
		chk({track_en, analog_power}, 2'h3, "idle tracking");
		standby <= 1;
		repeat (4) @(posedge clk);
		chk({track_en, analog_power}, 2'h0, "standby");
		report_and_stop();
	end
	// hang guard, far beyond the few thousand cycles the sequence needs
	initial begin
		#(25 * 40000);
		n_errors++;
		$display("BAD %0t watchdog expired", $time);
		report_and_stop();
	end
endmodule // tb
`default_nettype wire
